// *** verilog/jesd_sample_lane_mapper.sv ***
`timescale 1ns/1ps
// Function
// R1 - Mode 1: lanes 0-2 pack A0,A1,B0,B1 twelve-bit in two octets.
// R2 - Mode 6: same six-lane split, lanes 3-5 carry C0,C1,D0,D1.
// R3 - Mode 2: one octet per lane, lanes 0-3 carry A,B,C,D.
// R4 - Mode 3: lane per channel, four 10-bit samples in five octets.
// R5 - Mode 4: three lanes, one 12-bit sample per channel.
// R6 - Mode 5: two lanes, A then B on lane 0, C then D on 1.
// R7 - Mode 7: one octet per lane, lanes 0-3 carry A,B,C,D.
// R8 - Mode 8: lane per channel, two 12-bit samples in three octets.
// R9 - Mode 9: eight lanes, even samples on even lane, odd on odd.
// R10 - Mode 10: lane pairs, even samples 0,2,4,6 and odd 1,3,5,7.
// R11 - Unused tail bits of every lane frame are zero.
// R12 - Each sample is placed most significant bit first.
// R13 - Only the lowest lanes for the mode are enabled, rest off.
// R14 - Link mode is latched only while the link is stopped.
module jesd_sample_lane_mapper (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire lane_map_pkg::mode_t LINK_MODE,
    input wire logic LINK_RUN,
    input wire logic SAMPLE_VALID,
    input wire logic [lane_map_pkg::CH_W-1:0] SAMPLE_A,
    input wire logic [lane_map_pkg::CH_W-1:0] SAMPLE_B,
    input wire logic [lane_map_pkg::CH_W-1:0] SAMPLE_C,
    input wire logic [lane_map_pkg::CH_W-1:0] SAMPLE_D,
    output logic SAMPLE_READY,
    output logic FRAME_VALID,
    input wire logic FRAME_READY,
    output lane_map_pkg::lane_bus_t LANE_DATA,
    output logic [lane_map_pkg::OCT_W-1:0] FRAME_OCTETS,
    output logic [lane_map_pkg::LANES-1:0] LANE_EN
);
    import lane_map_pkg::*;

    typedef enum logic [1:0] {COLLECT, PACK, SEND} state_t;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    mode_t mode_s1_r;
    mode_t mode_s2_r;
    logic run_s1_r;
    logic run_s2_r;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_s1_r <= MODE_RST;
            mode_s2_r <= MODE_RST;
            run_s1_r <= 1'b0;
            run_s2_r <= 1'b0;
        end else begin
            mode_s1_r <= LINK_MODE;
            mode_s2_r <= mode_s1_r;
            run_s1_r <= LINK_RUN;
            run_s2_r <= run_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Sample buffering
    // ------------------------------------------------------------------
    stream_if #(.W(GRP_W)) in_s ();
    stream_if #(.W(GRP_W)) out_s ();

    assign in_s.valid = SAMPLE_VALID;
    assign in_s.data = {SAMPLE_A, SAMPLE_B, SAMPLE_C, SAMPLE_D};
    assign SAMPLE_READY = in_s.ready;

    sample_fifo #(.WIDTH(GRP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst_n(RSTN),
        .wr(in_s.snk),
        .rd(out_s.src)
    );

    // ------------------------------------------------------------------
    // Mode tables
    // ------------------------------------------------------------------
    function automatic logic [LANES-1:0] lanes_of(input mode_t m);
        case (m)
            MODE_1, MODE_6: lanes_of = LANES_6;
            MODE_2, MODE_3, MODE_7, MODE_8: lanes_of = LANES_4;
            MODE_4: lanes_of = LANES_3;
            MODE_5: lanes_of = LANES_2;
            MODE_9, MODE_10: lanes_of = LANES_8;
            default: lanes_of = LANES_OFF;
        endcase
    endfunction

    function automatic logic [OCT_W-1:0] octets_of(input mode_t m);
        case (m)
            MODE_2, MODE_7, MODE_9: octets_of = 3'h1;
            MODE_1, MODE_4, MODE_5, MODE_6: octets_of = 3'h2;
            MODE_8: octets_of = 3'h3;
            MODE_3, MODE_10: octets_of = 3'h5;
            default: octets_of = 3'h1;
        endcase
    endfunction

    // Index of the last sample group a frame needs.
    function automatic logic [IDX_W-1:0] last_of(input mode_t m);
        case (m)
            MODE_1, MODE_6, MODE_8, MODE_9: last_of = 3'h1;
            MODE_3: last_of = 3'h3;
            MODE_10: last_of = 3'h7;
            default: last_of = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Sample selection and lane packing
    // ------------------------------------------------------------------
    // Samples arrive MSB-justified; narrow modes keep the top bits.
    function automatic logic [CH_W-1:0] smp(input grp_arr_t g,
                                            input int i, input int ch);
        smp = g[i][GRP_W-1-ch*CH_W -: CH_W];
    endfunction

    function automatic logic [7:0] s8(input grp_arr_t g,
                                      input int i, input int ch);
        logic [CH_W-1:0] t;
        t = smp(g, i, ch);
        s8 = t[11:4];
    endfunction

    function automatic logic [9:0] s10(input grp_arr_t g,
                                       input int i, input int ch);
        logic [CH_W-1:0] t;
        t = smp(g, i, ch);
        s10 = t[11:2];
    endfunction

    function automatic lane_bus_t pack(input mode_t m, input grp_arr_t g);
        logic [CH_W-1:0] p0;
        logic [CH_W-1:0] p1;
        logic [CH_W-1:0] q0;
        logic [CH_W-1:0] q1;
        pack = '0; // [R11]
        case (m)
            MODE_1, MODE_6: begin
                for (int k = 0; k < 2; k++) begin
                    p0 = smp(g, 0, 2*k);
                    p1 = smp(g, 1, 2*k);
                    q0 = smp(g, 0, 2*k+1);
                    q1 = smp(g, 1, 2*k+1);
                    pack[3*k] = {p0, p1[11:8], 24'h0}; // [R1] [R2] [R12]
                    pack[3*k+1] = {p1[7:0], q0[11:4], 24'h0}; // [R1] [R2]
                    pack[3*k+2] = {q0[3:0], q1, 24'h0}; // [R1] [R2]
                end
            end
            MODE_2, MODE_7: begin
                for (int k = 0; k < NCH; k++) begin
                    pack[k] = {s8(g, 0, k), 32'h0}; // [R3] [R7]
                end
            end
            MODE_3: begin
                for (int k = 0; k < NCH; k++) begin
                    pack[k] = {s10(g, 0, k), s10(g, 1, k),
                               s10(g, 2, k), s10(g, 3, k)}; // [R4] [R12]
                end
            end
            MODE_4: begin
                p0 = smp(g, 0, 0);
                p1 = smp(g, 0, 1);
                q0 = smp(g, 0, 2);
                q1 = smp(g, 0, 3);
                pack[0] = {p0, p1[11:8], 24'h0}; // [R5]
                pack[1] = {p1[7:0], q0[11:4], 24'h0}; // [R5]
                pack[2] = {q0[3:0], q1, 24'h0}; // [R5]
            end
            MODE_5: begin
                pack[0] = {s8(g, 0, 0), s8(g, 0, 1), 24'h0}; // [R6]
                pack[1] = {s8(g, 0, 2), s8(g, 0, 3), 24'h0}; // [R6]
            end
            MODE_8: begin
                for (int k = 0; k < NCH; k++) begin
                    pack[k] = {smp(g, 0, k), smp(g, 1, k), 16'h0}; // [R8]
                end
            end
            MODE_9: begin
                for (int k = 0; k < NCH; k++) begin
                    pack[2*k] = {s8(g, 0, k), 32'h0}; // [R9]
                    pack[2*k+1] = {s8(g, 1, k), 32'h0}; // [R9]
                end
            end
            MODE_10: begin
                for (int k = 0; k < NCH; k++) begin
                    pack[2*k] = {s10(g, 0, k), s10(g, 2, k),
                                 s10(g, 4, k), s10(g, 6, k)}; // [R10]
                    pack[2*k+1] = {s10(g, 1, k), s10(g, 3, k),
                                   s10(g, 5, k), s10(g, 7, k)}; // [R10]
                end
            end
            default: pack = '0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Frame assembly
    // ------------------------------------------------------------------
    state_t state_r;
    state_t state_nxt;
    mode_t mode_r;
    grp_arr_t grp_r;
    logic [IDX_W-1:0] idx_r;
    lane_bus_t lane_r;
    logic valid_r;
    logic [OCT_W-1:0] oct_r;
    logic [LANES-1:0] en_r;

    wire take = out_s.valid && out_s.ready;
    wire last_grp = (idx_r == last_of(mode_r));
    wire sent = valid_r && FRAME_READY;
    wire lane_bus_t packed_w = pack(mode_r, grp_r);

    // Reading stalls while a frame waits, so back-pressure reaches the pins.
    assign out_s.ready = run_s2_r && (state_r == COLLECT);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            COLLECT: state_nxt = (take && last_grp) ? PACK : COLLECT;
            PACK: state_nxt = SEND;
            SEND: state_nxt = sent ? COLLECT : SEND;
            default: state_nxt = COLLECT;
        endcase
        if (!run_s2_r) begin
            state_nxt = COLLECT;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_r <= MODE_RST;
            en_r <= LANES_OFF;
            oct_r <= '0;
        end else if (!run_s2_r) begin
            // A mode change mid-link would tear frames apart.
            mode_r <= mode_s2_r; // [R14]
            en_r <= lanes_of(mode_s2_r); // [R13]
            oct_r <= octets_of(mode_s2_r);
        end
    end

    always_ff @(posedge MCLK) begin
        if (take) begin
            grp_r[idx_r] <= out_s.data;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= COLLECT;
            idx_r <= '0;
            lane_r <= '0;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= (!run_s2_r || (take && last_grp)) ? '0 :
                     (take ? idx_r + 1'b1 : idx_r);
            lane_r <= (state_r == PACK) ? packed_w : lane_r;
            valid_r <= run_s2_r && (state_nxt == SEND);
        end
    end

    assign LANE_DATA = lane_r;
    assign FRAME_VALID = valid_r;
    assign FRAME_OCTETS = oct_r;
    assign LANE_EN = en_r;
endmodule

// *** verilog/lane_map_pkg.sv ***
package lane_map_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CH_W = 12;
    localparam int NCH = 4;
    localparam int GRP_W = CH_W * NCH;
    localparam int LANES = 8;
    localparam int LANE_W = 40;
    localparam int GRP_MAX = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int MODE_W = 4;
    localparam int IDX_W = 3;
    localparam int OCT_W = 3;

    typedef logic [LANES-1:0][LANE_W-1:0] lane_bus_t;
    typedef logic [GRP_MAX-1:0][GRP_W-1:0] grp_arr_t;
    typedef logic [MODE_W-1:0] mode_t;

    // ------------------------------------------------------------------
    // Link mode codes
    // ------------------------------------------------------------------
    localparam mode_t MODE_1 = 4'h1;
    localparam mode_t MODE_2 = 4'h2;
    localparam mode_t MODE_3 = 4'h3;
    localparam mode_t MODE_4 = 4'h4;
    localparam mode_t MODE_5 = 4'h5;
    localparam mode_t MODE_6 = 4'h6;
    localparam mode_t MODE_7 = 4'h7;
    localparam mode_t MODE_8 = 4'h8;
    localparam mode_t MODE_9 = 4'h9;
    localparam mode_t MODE_10 = 4'ha;

    // ------------------------------------------------------------------
    // Active lane masks and reset values
    // ------------------------------------------------------------------
    localparam logic [LANES-1:0] LANES_2 = 8'h03;
    localparam logic [LANES-1:0] LANES_3 = 8'h07;
    localparam logic [LANES-1:0] LANES_4 = 8'h0f;
    localparam logic [LANES-1:0] LANES_6 = 8'h3f;
    localparam logic [LANES-1:0] LANES_8 = 8'hff;
    localparam logic [LANES-1:0] LANES_OFF = 8'h00;
    localparam mode_t MODE_RST = 4'h0;
endpackage

// *** verilog/stream_if.sv ***
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** verilog/sample_fifo.sv ***
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    stream_if.snk wr,
    stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ZERO = '0;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    // Ready and valid come straight from flops, with no gate behind them.
    logic room_r;
    logic avail_r;
    wire push = wr.valid && room_r;
    wire pop = rd.ready && avail_r;

    assign wr.ready = room_r;
    assign rd.valid = avail_r;
    assign rd.data = mem[rp_r];
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            room_r <= 1'b1;
            avail_r <= 1'b0;
        end else begin
            wp_r <= push ? ((wp_r == PTR_LAST) ? '0 : wp_r + 1'b1) : wp_r;
            rp_r <= pop ? ((rp_r == PTR_LAST) ? '0 : rp_r + 1'b1) : rp_r;
            cnt_r <= cnt_nxt;
            room_r <= (cnt_nxt != CNT_FULL);
            avail_r <= (cnt_nxt != CNT_ZERO);
        end
    end
endmodule

// *** verif/lane_map_sva.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Lane mapper checker
// ---------------------------------------------------------------
module lane_map_sva (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic LINK_RUN,
    input wire logic FRAME_VALID,
    input wire logic FRAME_READY,
    input wire lane_map_pkg::lane_bus_t LANE_DATA,
    input wire logic [lane_map_pkg::OCT_W-1:0] FRAME_OCTETS,
    input wire logic [lane_map_pkg::LANES-1:0] LANE_EN
);
    import lane_map_pkg::*;
    logic off_dirty;
    logic tail_dirty;
    always_comb begin
        off_dirty = 1'b0;
        tail_dirty = 1'b0;
        for (int l = 0; l < LANES; l++) begin
            off_dirty |= !LANE_EN[l] && (LANE_DATA[l] != '0);
            tail_dirty |= ((LANE_DATA[l] << (8 * FRAME_OCTETS)) != '0);
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Run must be high past the two-stage sync before a hold is owed.
    chk_valid_holds: assert property (FRAME_VALID && !FRAME_READY &&
        LINK_RUN && $past(LINK_RUN) && $past(LINK_RUN, 2) |=> FRAME_VALID)
        else $error("frame valid dropped before it was taken");
    chk_data_stable: assert property (FRAME_VALID && !FRAME_READY &&
        LINK_RUN && $past(LINK_RUN) && $past(LINK_RUN, 2) |=>
        $stable(LANE_DATA)) else $error("lane data moved while offered");
    chk_take_drops: assert property (FRAME_VALID && FRAME_READY
        |=> !FRAME_VALID) else $error("frame valid held after take");
    chk_run_stops: assert property (!LINK_RUN [*3] |=> !FRAME_VALID)
        else $error("frame offered while link stopped");
    chk_mode_frozen: assert property (LINK_RUN && $past(LINK_RUN) &&
        $past(LINK_RUN, 2) && $past(LINK_RUN, 3) |->
        $stable(LANE_EN) && $stable(FRAME_OCTETS))
        else $error("lane setup changed while running");
    chk_lanes_low: assert property (
        ((LANE_EN + 8'h01) & LANE_EN) == 8'h00)
        else $error("enabled lanes are not the lowest ones");
    chk_off_quiet: assert property (FRAME_VALID |-> !off_dirty)
        else $error("disabled lane carries data");
    chk_tail_zero: assert property (FRAME_VALID
        |-> !tail_dirty) else $error("unused octets are not zero");
    chk_three_oct: assert property (FRAME_OCTETS == 3'h3
        |-> LANE_EN == LANES_4) else $error("three octets need four lanes");
endmodule

bind jesd_sample_lane_mapper lane_map_sva i_sva (.MCLK(MCLK), .RSTN(RSTN),
    .LINK_RUN(LINK_RUN), .FRAME_VALID(FRAME_VALID),
    .FRAME_READY(FRAME_READY), .LANE_DATA(LANE_DATA),
    .FRAME_OCTETS(FRAME_OCTETS), .LANE_EN(LANE_EN));

// *** verif/frame_sink.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Receiver model
// ---------------------------------------------------------------
module frame_sink (
    input wire logic clk,
    input wire logic slow,
    input wire logic valid,
    input wire lane_map_pkg::lane_bus_t data,
    output logic ready,
    output lane_map_pkg::lane_bus_t got,
    output int frames
);
    import lane_map_pkg::*;
    logic [1:0] cnt_r = 2'h0;
    initial begin
        ready = 1'b0;
        got = '0;
        frames = 0;
    end
    // A slow receiver accepts in one cycle of four, to stall the FIFO.
    always @(posedge clk) begin
        cnt_r <= cnt_r + 2'h1;
        ready <= !slow || (cnt_r == 2'h2);
        if (valid && ready) begin
            got <= data;
            frames <= frames + 1;
        end
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------
module tb;
    import lane_map_pkg::*;
    logic clk, rst_n, run, sv, sr, fv, fr, slow;
    mode_t lmode;
    logic [CH_W-1:0] sa, sb, sc, sd;
    lane_bus_t ld, got;
    logic [OCT_W-1:0] fo;
    logic [LANES-1:0] le;
    int frames;
    int gbase = 0;
    int bad_count = 0;
    int samples_checked = 0;
    int nw[11] = '{0, 2, 1, 4, 1, 1, 2, 1, 2, 2, 8};
    logic [7:0] ens[11] = '{8'h00, 8'h3f, 8'h0f, 8'h0f, 8'h07, 8'h03,
        8'h3f, 8'h0f, 8'h0f, 8'hff, 8'hff};
    logic [2:0] octs[11] = '{3'h1, 3'h2, 3'h1, 3'h5, 3'h2, 3'h2, 3'h2,
        3'h1, 3'h3, 3'h1, 3'h5};

    jesd_sample_lane_mapper i_dut (.MCLK(clk), .RSTN(rst_n),
        .LINK_MODE(lmode), .LINK_RUN(run), .SAMPLE_VALID(sv),
        .SAMPLE_A(sa), .SAMPLE_B(sb), .SAMPLE_C(sc), .SAMPLE_D(sd),
        .SAMPLE_READY(sr), .FRAME_VALID(fv), .FRAME_READY(fr),
        .LANE_DATA(ld), .FRAME_OCTETS(fo), .LANE_EN(le));
    frame_sink i_rx (.clk(clk), .slow(slow), .valid(fv), .data(ld),
        .ready(fr), .got(got), .frames(frames));

    function automatic logic [11:0] smp(int g, int c, int w);
        return 12'(12'h9c3 + g * 12'h217 + c * 12'h4b1) >> (12 - w);
    endfunction

    // Narrow modes keep only the top bits of each sample.
    function automatic lane_bus_t mk(mode_t m, int b);
        lane_bus_t e;
        logic [95:0] s;
        e = '0;
        s = '0;
        for (int c = 0; c < 4; c++) begin
            case (m)
                MODE_1, MODE_6:
                    s = {s[71:0], smp(b, c, 12), smp(b + 1, c, 12)};
                MODE_4: s = {s[83:0], smp(b, c, 12)};
                MODE_2, MODE_7: e[c] = {8'(smp(b, c, 8)), 32'h0};
                MODE_5: e[c/2][39-8*(c%2) -: 8] = 8'(smp(b, c, 8));
                MODE_8: e[c] = {smp(b, c, 12), smp(b + 1, c, 12), 16'h0};
                MODE_3: for (int i = 0; i < 4; i++)
                    e[c][39-10*i -: 10] = 10'(smp(b + i, c, 10));
                MODE_9: for (int i = 0; i < 2; i++)
                    e[2*c+i] = {8'(smp(b + i, c, 8)), 32'h0};
                MODE_10: for (int i = 0; i < 8; i++)
                    e[2*c+i%2][39-10*(i/2) -: 10] = 10'(smp(b + i, c, 10));
                default: ;
            endcase
        end
        for (int l = 0; l < 6; l++) begin
            if (m == MODE_1 || m == MODE_6) e[l] = {s[95-16*l -: 16], 24'h0};
            if (m == MODE_4 && l < 3) e[l] = {s[47-16*l -: 16], 24'h0};
        end
        return e;
    endfunction

    task automatic check(string what, logic [319:0] exp, logic [319:0] seen);
        samples_checked++;
        if (exp !== seen) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic set_mode(int m);
        run <= 1'b0;
        lmode <= 4'(m);
        repeat (6) @(posedge clk);
        check("lane enable", 320'(ens[m]), 320'(le));
        check("frame octets", 320'(octs[m]), 320'(fo));
        run <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic push_n(int b, int n);
        for (int g = b; g < b + n; g++) begin
            sv <= 1'b1;
            sa <= smp(g, 0, 12);
            sb <= smp(g, 1, 12);
            sc <= smp(g, 2, 12);
            sd <= smp(g, 3, 12);
            @(posedge clk);
            while (sr !== 1'b1) @(posedge clk);
        end
        sv <= 1'b0;
    endtask

    // Two frames back to back, the slow receiver on odd modes.
    task automatic run_mode(int m);
        int b;
        b = gbase;
        gbase += 2 * nw[m];
        set_mode(m);
        slow <= 1'(m % 2);
        fork
            push_n(b, 2 * nw[m]);
            for (int k = 0; k < 2; k++) begin
                int f;
                f = frames;
                for (int t = 0; t < 300 && frames == f; t++) @(posedge clk);
                check("lane frame",
                    mk(4'(m), b + k * nw[m]), got);
            end
        join
    endtask

    // A stopped link leaves the FIFO to fill; a reset then empties it.
    task automatic fill_fifo();
        int n;
        n = 0;
        sv <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (sr === 1'b1) n++;
        end
        sv <= 1'b0;
        check("words accepted", 320'(n), 320'(FIFO_DEPTH));
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("ready after reset", 320'(1), 320'(sr));
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        sv = 1'b0;
        slow = 1'b0;
        lmode = MODE_RST;
        {sa, sb, sc, sd} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        set_mode(0);
        run <= 1'b0;
        // Let the stop pass the synchroniser, or the mapper drains a word.
        repeat (4) @(posedge clk);
        fill_fifo();
        for (int m = 1; m <= 10; m++) run_mode(m);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule
